//--- design/sbcsd_pkg.sv
/*
 package for the status and diagnosis readback block: frame field
 positions, register select codes, fault code encodings and carriers.
 assumes a 16-bit serial frame, most significant bit first.
*/
package sbcsd_pkg;
   localparam int FRAME_W = 16;
   localparam int CNT_W   = 5;
   localparam logic [4:0] FRAME_LEN = 5'h10;
   // frame header positions
   localparam int SEL_HI = 15;
   localparam int SEL_LO = 14;
   localparam int RBSEL_BIT = 13;
   localparam int NOWR_BIT  = 12;
   localparam logic [1:0] SEL_DIAG   = 2'h0;
   localparam logic [1:0] SEL_STATUS = 2'h1;
   // can fault codes
   localparam logic [3:0] CANF_TX_DOM  = 4'hf;
   localparam logic [3:0] CANF_RX_DOM  = 4'he;
   localparam logic [3:0] CANF_RX_REC  = 4'hd;
   localparam logic [3:0] CANF_BUS_DOM = 4'hc;
   localparam logic [3:0] CANF_H_L     = 4'h9;
   localparam logic [3:0] CANF_L_SUP   = 4'h8;
   localparam logic [3:0] CANF_H_GND   = 4'h6;
   localparam logic [3:0] CANF_L_GND   = 4'h5;
   localparam logic [3:0] CANF_H_SUP   = 4'h4;
   localparam logic [3:0] CANF_NONE    = 4'h0;
   // lin fault codes
   localparam logic [1:0] LINF_TX_DOM = 2'h3;
   localparam logic [1:0] LINF_GND    = 2'h2;
   localparam logic [1:0] LINF_BAT    = 2'h1;
   localparam logic [1:0] LINF_NONE   = 2'h0;
   // can mode codes
   localparam logic [1:0] CANM_ACTIVE = 2'h3;
   localparam logic [1:0] CANM_ONLINE = 2'h2;
   localparam logic [1:0] CANM_LISTEN = 2'h1;
   localparam logic [1:0] CANM_OFF    = 2'h0;
   localparam logic [3:0] RESET_CAUSE_RST = 4'h0;

   // raw can fault conditions, one bit each
   typedef struct packed {
      logic tx_dom;
      logic rx_dom;
      logic rx_rec;
      logic bus_dom;
      logic h_l;
      logic l_sup;
      logic h_gnd;
      logic l_gnd;
      logic h_sup;
   } sbcsd_canf_t;

   typedef struct packed {
      logic tx_dom;
      logic gnd;
      logic bat;
   } sbcsd_linf_t;

   // diagnosis word layout
   typedef struct packed {
      logic [1:0] sel;
      logic       rbsel;
      logic       nowr;
      logic       gnd_fault;
      logic [3:0] can_fault_code;
      logic [1:0] lin_fault_code;
      logic       aux_supply_ok;
      logic       transceiver_supply_ok;
      logic       core_supply_ok;
      logic [1:0] can_mode_report;
   } sbcsd_diag_t;

   // status word layout (low bits owned here)
   typedef struct packed {
      logic [1:0] sel;
      logic       rbsel;
      logic       nowr;
      logic [3:0] reset_cause;
      logic [2:0] upper;
      logic       wake_pin_level;
      logic       thermal_warning;
      logic       debug_mode_flag;
      logic       switch_output_state;
      logic       power_up_flag;
   } sbcsd_status_t;
endpackage

//--- design/sbcsd_sync.sv
/*
 two flip-flop level synchroniser, parameterised width.
 assumes the input is a slowly moving level from another domain.
*/
`timescale 1ns/1ns
module sbcsd_sync #(
   parameter int W = 1
) (
   // clock and reset
   input  wire logic         clk_i,
   input  wire logic         rst_b_i,
   // data
   input  wire logic [W-1:0] d_i,
   output logic      [W-1:0] q_o
);
   logic [W-1:0] meta;
   logic [W-1:0] next_meta;
   logic [W-1:0] next_q;

   // next values
   always_comb begin
      next_meta = d_i;
      next_q    = meta;
   end

   // registers
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         meta <= '0;
         q_o  <= '0;
      end else begin
         meta <= next_meta;
         q_o  <= next_q;
      end
   end
endmodule

//--- design/sbcsd_top.sv
/*
 status and diagnosis readback of a system basis chip: flag capture on
 the system clock, a 16-bit serial slave on the link clock, and the
 crossings between them.
 assumes spi mode 0 (sample on rising sck, shift on falling), frame
 framed by active-low chip select, sck idle low outside frames.
*/
// Behaviour
// - status bit 4 follows wake pin level
// - status bit 3 shows thermal warning
// - status bit 2 shows software development mode
// - status bit 1 shows switched output pin state
// - power-up flag set by power-on reset, cleared on normal mode entry
// - reset cause overwritten on every reset event, never cleared
// - diagnosis register readable in every mode
// - select bits 00 address diagnosis, device returns it
// - no-write flag 1 only reads; 0 also loads mode register (code loads it only for select 00 frames, not for status frames)
// - diagnosis bit 11 shows ground shift outside threshold
// - can fault clamp codes 1111, 1110, 1100, 1101
// - can fault short codes 1001, 1000, 0110, 0101, 0100, 0000
// - lin fault codes 11, 10, 01, 00
// - diagnosis bit 4 shows third regulator ok
// - diagnosis bit 3 zero while transceiver regulator disabled
// - core supply ok latches 0 on undervoltage, set by each diagnosis read
// - transceiver supply ok returns to 1 on reactivation
// - can mode report 11 active, 10 on-line, 01 listen, 00 off
`timescale 1ns/1ns
module sbcsd_top (
   // system clock and reset
   input  wire logic                 clk_sys_i,
   input  wire logic                 rst_b_i,
   // serial link
   input  wire logic                 spi_sck_i,
   input  wire logic                 spi_cs_b_i,
   input  wire logic                 spi_mosi_i,
   output logic                      spi_miso_o,
   // status sources (analog comparators, asynchronous)
   input  wire logic                 wake_pin_level_i,
   input  wire logic                 thermal_warning_i,
   input  wire logic                 debug_mode_i,
   input  wire logic                 switch_output_i,
   input  wire logic                 ground_offset_fault_i,
   input  wire logic                 aux_supply_ok_i,
   input  wire logic                 transceiver_supply_ok_i,
   input  wire logic                 core_undervoltage_i,
   input  wire sbcsd_pkg::sbcsd_canf_t can_fault_i,
   input  wire sbcsd_pkg::sbcsd_linf_t lin_fault_i,
   // device state, same clock domain
   input  wire logic [1:0]           can_mode_i,
   input  wire logic                 power_on_reset_i,
   input  wire logic                 normal_mode_entered_i,
   input  wire logic                 reset_event_i,
   input  wire logic [3:0]           reset_cause_i,
   input  wire logic [2:0]           status_upper_i,
   // mode register load
   output logic [15:0]               mode_word_o,
   output logic                      mode_load_o
);
   localparam int AW      = 20;
   // positions of the synchronised pin flags inside the sync bus
   localparam int IX_LIN  = 0;
   localparam int IX_CAN  = 3;
   localparam int IX_UV   = 12;
   localparam int IX_TRX  = 13;
   localparam int IX_AUX  = 14;
   localparam int IX_GND  = 15;
   localparam int IX_SW   = 16;
   localparam int IX_DBG  = 17;
   localparam int IX_THM  = 18;
   localparam int IX_WAKE = 19;
   localparam int CANF_W  = $bits(sbcsd_pkg::sbcsd_canf_t);
   localparam int LINF_W  = $bits(sbcsd_pkg::sbcsd_linf_t);

   // priority encoder: one defined code, reserved codes unreachable
   function automatic logic [3:0] can_code(input sbcsd_pkg::sbcsd_canf_t f);
      logic [3:0] c;
      c = sbcsd_pkg::CANF_NONE;
      if (f.tx_dom)       c = sbcsd_pkg::CANF_TX_DOM;
      else if (f.rx_dom)  c = sbcsd_pkg::CANF_RX_DOM;
      else if (f.bus_dom) c = sbcsd_pkg::CANF_BUS_DOM;
      else if (f.rx_rec)  c = sbcsd_pkg::CANF_RX_REC;
      else if (f.h_l)     c = sbcsd_pkg::CANF_H_L;
      else if (f.l_sup)   c = sbcsd_pkg::CANF_L_SUP;
      else if (f.h_gnd)   c = sbcsd_pkg::CANF_H_GND;
      else if (f.l_gnd)   c = sbcsd_pkg::CANF_L_GND;
      else if (f.h_sup)   c = sbcsd_pkg::CANF_H_SUP;
      return c;
   endfunction

   function automatic logic [1:0] lin_code(input sbcsd_pkg::sbcsd_linf_t f);
      logic [1:0] c;
      c = sbcsd_pkg::LINF_NONE;
      if (f.tx_dom)   c = sbcsd_pkg::LINF_TX_DOM;
      else if (f.gnd) c = sbcsd_pkg::LINF_GND;
      else if (f.bat) c = sbcsd_pkg::LINF_BAT;
      return c;
   endfunction

   // ---- asynchronous inputs into system domain
   logic [AW-1:0] async_raw;
   logic [AW-1:0] async_s;
   assign async_raw = {wake_pin_level_i, thermal_warning_i, debug_mode_i, switch_output_i,
                       ground_offset_fault_i, aux_supply_ok_i, transceiver_supply_ok_i,
                       core_undervoltage_i, can_fault_i, lin_fault_i};

   sbcsd_sync #(.W(AW)) u_sync_in (
      .clk_i   (clk_sys_i),
      .rst_b_i (rst_b_i),
      .d_i     (async_raw),
      .q_o     (async_s)
   );

   // ---- system domain flags
   logic       power_up_flag;
   logic       next_power_up_flag;
   logic [3:0] reset_cause;
   logic [3:0] next_reset_cause;
   logic       core_ok;
   logic       next_core_ok;
   logic       rd_ack_s;          // synchronised read toggle from link
   logic       rd_ack_d;
   logic       next_rd_ack_d;
   logic       rd_pulse;
   logic        rd_pend;          // frame received, chip select not yet released
   logic        next_rd_pend;
   logic        rd_apply;         // frame closed, safe to act on it
   logic        frame_s;          // synchronised chip select, high inside a frame
   logic        lnk_tog;          // toggles once per complete frame, link domain
   logic [15:0] lnk_word;         // last complete frame, held between frames
   logic        wr_diag;
   logic [15:0] next_mode_word;
   logic        next_mode_load;
   assign rd_pulse = rd_ack_s ^ rd_ack_d;
   assign rd_apply = rd_pend & ~frame_s;
   // frame word is quiet here: it only moves at the last edge of the next frame
   assign wr_diag  = lnk_word[sbcsd_pkg::SEL_HI -: 2] == sbcsd_pkg::SEL_DIAG;

   // read toggle and chip select into the system domain
   sbcsd_sync #(.W(1)) u_sync_tog (
      .clk_i   (clk_sys_i),
      .rst_b_i (rst_b_i),
      .d_i     (lnk_tog),
      .q_o     (rd_ack_s)
   );

   sbcsd_sync #(.W(1)) u_sync_cs (
      .clk_i   (clk_sys_i),
      .rst_b_i (rst_b_i),
      .d_i     (~spi_cs_b_i),
      .q_o     (frame_s)
   );

   // flag next values
   always_comb begin
      next_power_up_flag = power_up_flag;
      if (power_on_reset_i)
         next_power_up_flag = 1'b1;
      else if (normal_mode_entered_i)
         next_power_up_flag = 1'b0;
      next_reset_cause = reset_cause;
      if (reset_event_i)
         next_reset_cause = reset_cause_i;
      next_core_ok = core_ok;
      if (async_s[IX_UV])
         next_core_ok = 1'b0;
      else if (rd_apply && wr_diag)
         next_core_ok = 1'b1;
      next_rd_ack_d = rd_ack_s;
      // a new frame wins over the clear of the pending flag
      next_rd_pend = rd_pend;
      if (rd_pulse)
         next_rd_pend = 1'b1;
      else if (rd_apply)
         next_rd_pend = 1'b0;
      // mode load only once the frame is closed
      next_mode_word = mode_word_o;
      next_mode_load = 1'b0;
      if (rd_apply && wr_diag && !lnk_word[sbcsd_pkg::NOWR_BIT]) begin
         next_mode_word = lnk_word;
         next_mode_load = 1'b1;
      end
   end

   // flag registers
   always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         power_up_flag <= 1'b1;
         reset_cause   <= sbcsd_pkg::RESET_CAUSE_RST;
         core_ok       <= 1'b1;
         rd_ack_d      <= 1'b0;
         rd_pend       <= 1'b0;
         mode_word_o   <= 16'h0000;
         mode_load_o   <= 1'b0;
      end else begin
         power_up_flag <= next_power_up_flag;
         reset_cause   <= next_reset_cause;
         core_ok       <= next_core_ok;
         rd_ack_d      <= next_rd_ack_d;
         rd_pend       <= next_rd_pend;
         mode_word_o   <= next_mode_word;
         mode_load_o   <= next_mode_load;
      end
   end

   // assembled words, stable between system edges
   sbcsd_pkg::sbcsd_diag_t   diag_w;
   sbcsd_pkg::sbcsd_status_t stat_w;
   sbcsd_pkg::sbcsd_linf_t   lin_s;
   assign lin_s = async_s[IX_LIN +: LINF_W];
   always_comb begin
      diag_w.sel                   = sbcsd_pkg::SEL_DIAG;
      diag_w.rbsel                 = 1'b1;
      diag_w.nowr                  = 1'b1;
      diag_w.gnd_fault             = async_s[IX_GND];
      diag_w.can_fault_code        = can_code(async_s[IX_CAN +: CANF_W]);
      diag_w.lin_fault_code        = lin_code(lin_s);
      diag_w.aux_supply_ok         = async_s[IX_AUX];
      diag_w.transceiver_supply_ok = async_s[IX_TRX];
      diag_w.core_supply_ok        = core_ok;
      diag_w.can_mode_report       = can_mode_i;
      stat_w.sel                   = sbcsd_pkg::SEL_STATUS;
      stat_w.rbsel                 = 1'b1;
      stat_w.nowr                  = 1'b1;
      stat_w.reset_cause           = reset_cause;
      stat_w.upper                 = status_upper_i;
      stat_w.wake_pin_level        = async_s[IX_WAKE];
      stat_w.thermal_warning       = async_s[IX_THM];
      stat_w.debug_mode_flag       = async_s[IX_DBG];
      stat_w.switch_output_state   = async_s[IX_SW];
      stat_w.power_up_flag         = power_up_flag;
   end

   // snapshot words, frozen while a frame runs so the link sees one instant
   sbcsd_pkg::sbcsd_diag_t   diag_q;
   sbcsd_pkg::sbcsd_diag_t   next_diag_q;
   sbcsd_pkg::sbcsd_status_t stat_q;
   sbcsd_pkg::sbcsd_status_t next_stat_q;
   always_comb begin
      next_diag_q = diag_q;
      next_stat_q = stat_q;
      if (!frame_s) begin
         next_diag_q = diag_w;
         next_stat_q = stat_w;
      end
   end

   // snapshot registers
   always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         diag_q <= '0;
         stat_q <= '0;
      end else begin
         diag_q <= next_diag_q;
         stat_q <= next_stat_q;
      end
   end

   // link domain: frame state is cleared while chip select is high
   logic        lnk_rst_b;
   logic [4:0]  bit_cnt;
   logic [4:0]  next_bit_cnt;
   logic [14:0] rx_sr;
   logic [14:0] next_rx_sr;
   logic [1:0]  sel;
   logic [1:0]  next_sel;
   logic        next_lnk_tog;
   logic [15:0] next_lnk_word;
   logic [15:0] tx_word;
   logic [3:0]  tx_idx;
   logic        next_miso;
   assign lnk_rst_b = rst_b_i & ~spi_cs_b_i;

   // bit count, receive shift and select capture on rising link clock
   always_comb begin
      next_bit_cnt = bit_cnt;
      if (bit_cnt != sbcsd_pkg::FRAME_LEN)
         next_bit_cnt = bit_cnt + 5'h1;                // stops at 16, extra clocks ignored
      next_rx_sr = {rx_sr[13:0], spi_mosi_i};
      next_sel = sel;
      if (bit_cnt == 5'h1)
         next_sel = {rx_sr[0], spi_mosi_i};
   end

   // frame state registers
   always_ff @(posedge spi_sck_i or negedge lnk_rst_b) begin
      if (!lnk_rst_b) begin
         bit_cnt <= 5'h00;
         rx_sr   <= 15'h0000;
         sel     <= 2'h0;
      end else begin
         bit_cnt <= next_bit_cnt;
         rx_sr   <= next_rx_sr;
         sel     <= next_sel;
      end
   end

   // complete frame: word kept and toggle flipped for the system domain
   always_comb begin
      next_lnk_tog  = lnk_tog;
      next_lnk_word = lnk_word;
      if (bit_cnt == sbcsd_pkg::FRAME_LEN - 5'h1) begin
         next_lnk_tog  = ~lnk_tog;
         next_lnk_word = {rx_sr, spi_mosi_i};
      end
   end

   // frame hand-over registers, survive chip select release
   always_ff @(posedge spi_sck_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         lnk_tog  <= 1'b0;
         lnk_word <= 16'h0000;
      end else begin
         lnk_tog  <= next_lnk_tog;
         lnk_word <= next_lnk_word;
      end
   end

   // reply bit; the snapshot is frozen well before the third link edge
   always_comb begin
      tx_word   = (sel == sbcsd_pkg::SEL_DIAG) ? diag_q : stat_q;
      tx_idx    = 4'(sbcsd_pkg::FRAME_W - 1) - bit_cnt[3:0];
      next_miso = 1'b0;
      if (bit_cnt >= 5'h2 && bit_cnt < sbcsd_pkg::FRAME_LEN)
         next_miso = tx_word[tx_idx];
   end

   // reply shifted out on falling link clock
   always_ff @(negedge spi_sck_i or negedge lnk_rst_b) begin
      if (!lnk_rst_b) begin
         spi_miso_o <= 1'b0;
      end else begin
         spi_miso_o <= next_miso;
      end
   end
endmodule

//--- verification/sbcsd_host.sv
/*
 host master model: 16-bit frames msb first, mode 0, 80 ns link clock.
 assumes the bench calls xfer only while no frame is running.
*/
`timescale 1ns/1ns
module sbcsd_host (
   // serial link
   output logic      sck_o,
   output logic      cs_b_o,
   output logic      mosi_o,
   input  wire logic miso_i
);
   // link idle: clock low, chip select high
   initial begin
      sck_o = 1'b0;
      cs_b_o = 1'b1;
      mosi_o = 1'b0;
   end
   // one frame; reply taken on each rising clock
   task automatic xfer(input logic [15:0] tx, output logic [15:0] rx);
      cs_b_o = 1'b0;
      for (int i = 15; i >= 0; i--) begin
         mosi_o = tx[i];
         #40 sck_o = 1'b1;
         rx[i] = miso_i;
         #40 sck_o = 1'b0;
      end
      #40 cs_b_o = 1'b1;
      mosi_o = ~tx[0]; // released line shows no stale value
   endtask
endmodule

//--- verification/sbcsd_props.sv
/*
 checker for the readback block, bound to its top module.
 assumes flags are held steady around each frame.
*/
`timescale 1ns/1ns
module sbcsd_props (
   // clocks and reset
   input wire logic        clk_sys_i,
   input wire logic        rst_b_i,
   // link
   input wire logic        spi_sck_i,
   input wire logic        spi_cs_b_i,
   input wire logic        spi_mosi_i,
   input wire logic        spi_miso_o,
   // flags
   input wire logic        wake_pin_level_i,
   input wire logic        thermal_warning_i,
   input wire logic        switch_output_i,
   input wire logic        ground_offset_fault_i,
   input wire logic        aux_supply_ok_i,
   input wire logic        transceiver_supply_ok_i,
   // mode register load
   input wire logic [15:0] mode_word_o,
   input wire logic        mode_load_o
);
   logic [4:0] cnt;
   logic [4:0] next_cnt;
   logic [1:0] sel;
   logic [1:0] next_sel;
   // bit count and select capture within a frame
   always_comb begin
      next_cnt = cnt + 5'h1;
      next_sel = (cnt < 5'h2) ? {sel[0], spi_mosi_i} : sel;
   end
   always_ff @(posedge spi_sck_i or posedge spi_cs_b_i) begin
      if (spi_cs_b_i) begin
         cnt <= 5'h0;
         sel <= 2'h0;
      end else begin
         cnt <= next_cnt;
         sel <= next_sel;
      end
   end
   AST_WAKE: assert property (@(posedge spi_sck_i) disable iff (spi_cs_b_i)
      sel == 2'h1 && cnt == 5'hb |-> spi_miso_o == wake_pin_level_i) else $error("wake");
   AST_THERM: assert property (@(posedge spi_sck_i) disable iff (spi_cs_b_i)
      sel == 2'h1 && cnt == 5'hc |-> spi_miso_o == thermal_warning_i) else $error("therm");
   AST_SWITCH: assert property (@(posedge spi_sck_i) disable iff (spi_cs_b_i)
      sel == 2'h1 && cnt == 5'he |-> spi_miso_o == switch_output_i) else $error("switch");
   AST_GND: assert property (@(posedge spi_sck_i) disable iff (spi_cs_b_i)
      sel == 2'h0 && cnt == 5'h4 |-> spi_miso_o == ground_offset_fault_i) else $error("gnd");
   AST_AUX: assert property (@(posedge spi_sck_i) disable iff (spi_cs_b_i)
      sel == 2'h0 && cnt == 5'hb |-> spi_miso_o == aux_supply_ok_i) else $error("aux");
   AST_TRX: assert property (@(posedge spi_sck_i) disable iff (spi_cs_b_i)
      sel == 2'h0 && cnt == 5'hc |-> spi_miso_o == transceiver_supply_ok_i) else $error("trx");
   AST_LOAD_CS: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
      $rose(mode_load_o) |-> spi_cs_b_i) else $error("load inside frame");
   AST_LOAD_HDR: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
      mode_load_o |-> mode_word_o[15:12] == 4'h2) else $error("load header");
endmodule
bind sbcsd_top sbcsd_props u_props (.clk_sys_i, .rst_b_i, .spi_sck_i, .spi_cs_b_i,
   .spi_mosi_i, .spi_miso_o, .wake_pin_level_i, .thermal_warning_i, .switch_output_i,
   .ground_offset_fault_i, .aux_supply_ok_i, .transceiver_supply_ok_i, .mode_word_o,
   .mode_load_o);

//--- verification/sbcsd_bench.sv
/*
 self-checking bench: random flags read back through both registers.
 assumes the host model is the only link master.
*/
`timescale 1ns/1ns
module sbcsd_bench;
   logic clk_sys_i, rst_b_i, sck, cs_b, mosi, miso, uv, por, nme, rev, load, core, pwr, ok;
   logic [6:0]             lv;
   logic [1:0]             cm;
   logic [3:0]             rc, rcm;
   logic [2:0]             up;
   logic [15:0]            mw, lw, w, rx;
   sbcsd_pkg::sbcsd_canf_t cf;
   sbcsd_pkg::sbcsd_linf_t lf;
   int                     n_tests, n_mismatch, n_load, n0, k, cyc;
   int                     cc[9] = '{15, 14, 13, 12, 9, 8, 6, 5, 4};
   sbcsd_top dut (.clk_sys_i, .rst_b_i, .spi_sck_i(sck), .spi_cs_b_i(cs_b),
      .spi_mosi_i(mosi), .spi_miso_o(miso), .wake_pin_level_i(lv[6]),
      .thermal_warning_i(lv[5]), .debug_mode_i(lv[4]), .switch_output_i(lv[3]),
      .ground_offset_fault_i(lv[2]), .aux_supply_ok_i(lv[1]),
      .transceiver_supply_ok_i(lv[0]), .core_undervoltage_i(uv), .can_fault_i(cf),
      .lin_fault_i(lf), .can_mode_i(cm), .power_on_reset_i(por), .normal_mode_entered_i(nme),
      .reset_event_i(rev), .reset_cause_i(rc), .status_upper_i(up), .mode_word_o(mw),
      .mode_load_o(load));
   sbcsd_host host (.sck_o(sck), .cs_b_o(cs_b), .mosi_o(mosi), .miso_i(miso));
   // system clock
   initial begin
      clk_sys_i = 1'b0;
      forever #5 clk_sys_i = ~clk_sys_i;
   end
   // mode loads seen off the active edge, and the hang limit
   always @(negedge clk_sys_i) begin
      cyc++;
      if (load === 1'b1) begin
         n_load++;
         lw = mw;
      end
      if (cyc == 40000) begin
         n_mismatch++;
         end_sim();
      end
   end
   task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] s);
      n_tests++;
      if (e !== s) begin
         n_mismatch++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
      end
   endtask
   task automatic rd(input logic [15:0] tx);
      host.xfer(tx, rx);
      repeat (40) @(negedge clk_sys_i);
   endtask
   task end_sim;
      $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   // reset, then events, random flags and a diagnosis plus status read per round
   initial begin
      {rst_b_i, lv, cm, rc, up, cf, lf, uv, por, nme, rev} = '0;
      rcm = sbcsd_pkg::RESET_CAUSE_RST;
      core = 1'b1;
      void'($urandom(78));
      repeat (6) @(negedge clk_sys_i);
      rst_b_i = 1'b1;
      for (int i = 0; i < 40; i++) begin
         k = (i == 0) ? 0 : int'($urandom % 4);
         rc = 4'($urandom);
         {por, nme, rev, uv} = 4'h8 >> k;
         @(negedge clk_sys_i);
         {por, nme, rev, uv} = 4'h0;
         pwr = (k == 0) ? 1'b1 : (k == 1) ? 1'b0 : pwr;
         rcm = (k == 2) ? rc : rcm;
         core = (k == 3) ? 1'b0 : core;
         lv = 7'($urandom);
         cm = 2'($urandom);
         up = 3'($urandom);
         lf = 3'($urandom);
         cf = i[0] ? 9'h1 << ($urandom % 10) : 9'($urandom);
         w = {3'h1, 13'($urandom)};
         n0 = n_load;
         repeat (20) @(negedge clk_sys_i);
         rd(w);
         chk("diag", {4'h0, lv[2], 6'h0, lv[1:0], core, cm}, rx & 16'h081f);
         core = 1'b1;
         ok = (cf == 9'h0) && (rx[10:7] === 4'h0);
         for (int j = 0; j < 9; j++) ok |= cf[8 - j] && (rx[10:7] === cc[j][3:0]);
         chk("can code", 16'h1, {15'h0, ok});
         ok = (lf == 3'h0) && (rx[6:5] === 2'h0);
         for (int j = 0; j < 3; j++) ok |= lf[j] && (rx[6:5] === 2'(j + 1));
         chk("lin code", 16'h1, {15'h0, ok});
         chk("loads", w[12] ? 16'h0 : 16'h1, 16'(n_load - n0));
         if (!w[12]) chk("mode word", w, lw);
         rd(16'h7000);
         chk("status", {4'h0, rcm, up, lv[6:3], pwr}, {4'h0, rx[11:0]});
      end
      $display("test readback rounds done");
      end_sim();
   end
endmodule
